// ---- verilog/boot_mode_memory_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
module boot_mode_memory_decode #(
  parameter bit          ROM_VARIANT   = 1'b1,
  parameter int unsigned STOP_LONG     = 65535,
  parameter int unsigned LOAD_MAX      = 512,
  parameter int unsigned CLEAR_WORDS   = 256
) (
  input  wire logic                           clk,
  input  wire logic                           rstn,
  input  wire logic [3:0]                     avs_address,
  input  wire logic                           avs_read,
  input  wire logic                           avs_write,
  input  wire logic [31:0]                    avs_writedata,
  output logic [31:0]                         avs_readdata,
  output logic                                avs_waitrequest,
  input  wire logic                           mode_pin_high,
  input  wire logic                           mode_pin_middle,
  input  wire logic                           mode_pin_low,
  input  wire logic                           stop_request,
  input  wire logic                           load_word_valid,
  input  wire logic [boot_mode_pkg::DATA_W-1:0] load_word,
  input  wire logic                           mem_req,
  input  wire logic                           mem_write,
  input  wire logic                           mem_fetch,
  input  wire logic [boot_mode_pkg::ADDR_W-1:0] mem_addr,
  output logic                                boot_rom_enable,
  output logic                                program_rom_sel,
  output logic                                program_ram_enable,
  output logic                                periph_sel,
  output logic                                mem_write_allow,
  output logic                                reserved_hit,
  output logic [boot_mode_pkg::DATA_W-1:0]    reserved_data,
  output logic                                debug_port_enable,
  output logic                                clear_xy_active,
  output logic [8:0]                          clear_addr,
  output logic                                load_active,
  output logic [8:0]                          load_addr,
  output logic                                boot_chip_select_n,
  output logic                                serial_spi_slave,
  output logic                                serial_i2c_slave,
  output logic                                jump_valid,
  output logic [boot_mode_pkg::ADDR_W-1:0]    jump_addr,
  output logic                                core_run
);
  import boot_mode_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic        ms0, ms1, ms2;
    logic [2:0]  pin_s1, pin_s2;
    logic        stop_s1, stop_s2;
    logic        fresh;
    logic [23:0] operating_mode_control;
    logic        boot_go;
    boot_state_t st;
    logic [16:0] cnt;
    logic [31:0] rdata;
    logic        wait_n;
    logic        brom, prom, pram, per, wok, rsv;
    logic [23:0] rsv_d;
    logic        dbg, clr, ld, cs_n, spi, i2c, jv, run;
    logic [15:0] ja;
  } state_t;

  state_t s;
  state_t next_s;

  function automatic logic [2:0] mode_of(input logic [23:0] r);
    mode_of = {r[MODE_C_POS], r[MODE_B_POS], r[MODE_A_POS]};
  endfunction

  function automatic logic [23:0] with_mode(input logic [23:0] r, input logic [2:0] m);
    logic [23:0] t;
    t = r;
    t[MODE_C_POS] = m[2];
    t[MODE_B_POS] = m[1];
    t[MODE_A_POS] = m[0];
    with_mode = t;
  endfunction

  function automatic logic is_loader(input logic [2:0] m);
    is_loader = (m == MODE_EMI) || (m == MODE_SPI) || (m == MODE_I2C);
  endfunction

  logic [2:0]  mode;
  logic        in_prom;
  logic        in_periph;
  logic        in_rsv;
  logic        bus_req;
  logic [2:0]  strap;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s  = s;
    mode    = mode_of(s.operating_mode_control);
    strap   = s.pin_s2;
    bus_req = (avs_read || avs_write) && s.wait_n;
    next_s.pin_s1  = {mode_pin_high, mode_pin_middle, mode_pin_low};
    next_s.pin_s2  = s.pin_s1;
    next_s.stop_s1 = stop_request;
    next_s.stop_s2 = s.stop_s1;
    next_s.fresh   = 1'b0;
    next_s.jv      = 1'b0;
    next_s.boot_go = 1'b0;
    if (s.fresh) begin
      // mode 0 strap, and mode 2 on the standard variant, default to mode 1
      if (strap == MODE_NORMAL || (!ROM_VARIANT && strap == MODE_PROM)) begin
        strap = MODE_EMI;
      end
      next_s.operating_mode_control     = with_mode(s.operating_mode_control, strap);
      next_s.boot_go = 1'b1;
    end
    // avalon slave: one wait cycle, answer on the next edge
    next_s.wait_n = !bus_req;
    if (bus_req) begin
      next_s.rdata = 32'h0000_0000;
      case (avs_address)
        REG_MODE_CTRL: begin
          if (avs_write && !s.fresh) begin
            next_s.operating_mode_control = avs_writedata[23:0];
          end
          next_s.rdata = {8'h00, s.operating_mode_control};
        end
        REG_STATUS: next_s.rdata = {24'h00_0000, s.run, s.ld, s.clr, s.st, s.dbg, s.brom};
        REG_DECODE: next_s.rdata = {31'h0000_0000, ROM_VARIANT};
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end
    // boot rom and ram enables by mode
    next_s.brom = (mode != MODE_NORMAL);
    next_s.pram = (mode == MODE_NORMAL) || s.operating_mode_control[PRAM_A_POS] || s.operating_mode_control[PRAM_B_POS];
    in_prom   = ROM_VARIANT && mem_addr >= PROM_LO && mem_addr <= PROM_HI;
    in_periph = mem_addr >= PERIPH_ASSIGNED_LO;
    in_rsv    = mem_req && !in_prom && !in_periph &&
                (mem_addr >= PERIPH_LO || (mem_addr > PROM_HI && mem_addr < PERIPH_LO) ||
                 (mem_addr >= PROM_LO && !ROM_VARIANT));
    next_s.prom  = mem_req && in_prom;
    next_s.per   = mem_req && in_periph;
    next_s.rsv   = in_rsv;
    next_s.wok   = mem_req && mem_write && !in_rsv && !in_prom;
    next_s.rsv_d = (in_rsv && (!mem_write || mem_fetch)) ? RESERVED_WORD : 24'h00_0000;
    next_s.dbg   = 1'b1;
    case (s.st)
      ST_IDLE: begin
        // boot rom starts at reset vector
        if (s.boot_go) begin
          next_s.run = 1'b0;
          next_s.cnt = 17'd0;
          if (is_loader(mode)) begin
            next_s.st  = ST_CLEAR;
            next_s.clr = 1'b1;
          end else begin
            // rom variant wakes in program rom
            next_s.st = ST_DONE;
            next_s.ja = (mode == MODE_PROM) ? ROM_CONT_ADDR : RESET_VECTOR;
          end
        end else if (s.stop_s2 && s.run) begin
          next_s.st  = ST_STOP;
          next_s.run = 1'b0;
        end
      end
      ST_CLEAR: begin
        if (s.cnt == 17'(CLEAR_WORDS - 1)) begin
          next_s.st  = ST_LOAD;
          next_s.clr = 1'b0;
          next_s.ld  = 1'b1;
          next_s.cnt = 17'd0;
        end else begin
          next_s.cnt = s.cnt + 17'd1;
        end
      end
      ST_LOAD: begin
        // load up to the word limit
        if (load_word_valid) begin
          if (s.cnt == 17'(LOAD_MAX - 1)) begin
            next_s.st = ST_DONE;
            next_s.ld = 1'b0;
            next_s.ja = RESET_VECTOR;
            next_s.operating_mode_control = with_mode(s.operating_mode_control, MODE_NORMAL);
          end else begin
            next_s.cnt = s.cnt + 17'd1;
          end
        end
      end
      ST_DONE: begin
        next_s.jv  = 1'b1;
        next_s.run = 1'b1;
        next_s.st  = ST_IDLE;
      end
      ST_STOP: begin
        if (!s.stop_s2) begin
          next_s.st  = ST_WAKE;
          next_s.cnt = s.operating_mode_control[STOP_DLY_POS] ? 17'(STOP_SHORT_CYC - 1) : 17'(STOP_LONG - 1);
        end
      end
      ST_WAKE: begin
        if (s.cnt == 17'd0) begin
          next_s.st  = ST_IDLE;
          next_s.run = 1'b1;
        end else begin
          next_s.cnt = s.cnt - 17'd1;
        end
      end
      default: next_s.st = ST_IDLE;
    endcase
    // port roles follow the next state, in step with load_active
    next_s.spi   = (next_s.st == ST_LOAD) && mode == MODE_SPI;
    next_s.i2c   = (next_s.st == ST_LOAD) && mode == MODE_I2C;
    next_s.cs_n  = !((next_s.st == ST_LOAD) && mode == MODE_EMI);
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s        <= '0;
      s.fresh  <= 1'b1;
      s.wait_n <= 1'b1;
      s.cs_n   <= 1'b1;
      s.dbg    <= 1'b1;
      // synchroniser keeps running so the straps are settled at release
      s.pin_s1 <= {mode_pin_high, mode_pin_middle, mode_pin_low};
      s.pin_s2 <= s.pin_s1;
      // reset clears stop delay and ram enables
      s.operating_mode_control    <= MODE_CTRL_RST;
      s.st     <= ST_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign avs_readdata       = s.rdata;
  assign avs_waitrequest    = s.wait_n;
  assign boot_rom_enable    = s.brom;
  assign program_rom_sel    = s.prom;
  assign program_ram_enable = s.pram;
  assign periph_sel         = s.per;
  assign mem_write_allow    = s.wok;
  assign reserved_hit       = s.rsv;
  assign reserved_data      = s.rsv_d;
  assign debug_port_enable  = s.dbg;
  assign clear_xy_active    = s.clr;
  assign clear_addr         = s.cnt[8:0];
  assign load_active        = s.ld;
  assign load_addr          = s.cnt[8:0];
  assign boot_chip_select_n = s.cs_n;
  assign serial_spi_slave   = s.spi;
  assign serial_i2c_slave   = s.i2c;
  assign jump_valid         = s.jv;
  assign jump_addr          = s.ja;
  assign core_run           = s.run;

  ////////////////////////////////////////////////////////////////////////////
  // rom gating
  a_rom_gated: assert property (@(posedge clk) disable iff (!rstn)
    $past(mode) == MODE_NORMAL |-> !boot_rom_enable) else $error("boot rom on in mode 0");
  a_rsv_write: assert property (@(posedge clk) disable iff (!rstn)
    reserved_hit |-> !mem_write_allow) else $error("reserved write allowed");
  a_rsv_value: assert property (@(posedge clk) disable iff (!rstn)
    mem_req && !mem_write && in_rsv |=> reserved_data == RESERVED_WORD) else $error("bad reserved value");
  a_rsv_fetch: assert property (@(posedge clk) disable iff (!rstn)
    mem_req && mem_fetch && in_rsv |=> reserved_data == 24'h00_0005) else $error("bad fetch value");
  a_strap_load: assert property (@(posedge clk) disable iff (!rstn)
    $past(s.fresh) && !s.fresh |-> mode != MODE_NORMAL) else $error("strap gave mode 0");
  a_stop_short: assert property (@(posedge clk) disable iff (!rstn)
    s.st == ST_STOP && !s.stop_s2 && s.operating_mode_control[STOP_DLY_POS] |=> !core_run [*8] ##1 core_run)
    else $error("short stop delay wrong");
  a_clear_first: assert property (@(posedge clk) disable iff (!rstn)
    load_active |-> !clear_xy_active) else $error("load during clear");
  a_load_end: assert property (@(posedge clk) disable iff (!rstn)
    s.st == ST_LOAD && next_s.st == ST_DONE |=> mode == MODE_NORMAL ##1 jump_valid && jump_addr == RESET_VECTOR)
    else $error("loader end wrong");
  a_debug_on: assert property (@(posedge clk) disable iff (!rstn)
    debug_port_enable) else $error("debug port off");
  c_boot_emi: cover property (@(posedge clk) disable iff (!rstn) boot_chip_select_n == 1'b0);
  c_boot_done: cover property (@(posedge clk) disable iff (!rstn) jump_valid);
  c_stop_wake: cover property (@(posedge clk) disable iff (!rstn) s.st == ST_WAKE);
endmodule
`default_nettype wire

// ---- verilog/boot_mode_pkg.sv ----
package boot_mode_pkg;
  localparam int          ADDR_W        = 16;
  localparam int          DATA_W        = 24;
  localparam logic [3:0]  REG_MODE_CTRL = 4'h0;
  localparam logic [3:0]  REG_BOOT_CTRL = 4'h4;
  localparam logic [3:0]  REG_STATUS    = 4'h8;
  localparam logic [3:0]  REG_DECODE    = 4'hC;
  localparam int          MODE_A_POS    = 0;
  localparam int          MODE_B_POS    = 1;
  localparam int          MODE_C_POS    = 4;
  localparam int          STOP_DLY_POS  = 6;
  localparam int          PRAM_A_POS    = 2;
  localparam int          PRAM_B_POS    = 3;
  localparam logic [23:0] MODE_CTRL_RST = 24'h00_0000;
  localparam logic [23:0] RESERVED_WORD = 24'h00_0005;
  localparam logic [15:0] PROM_LO       = 16'h2000;
  localparam logic [15:0] PROM_HI       = 16'h47FF;
  localparam logic [15:0] PERIPH_LO     = 16'hFFC0;
  localparam logic [15:0] PERIPH_ASSIGNED_LO = 16'hFFE0;
  localparam logic [15:0] ROM_CONT_ADDR = 16'h2000;
  localparam logic [15:0] RESET_VECTOR  = 16'h0000;
  localparam int          BOOT_ROM_WORDS = 32;
  localparam int          LOAD_WORDS    = 512;
  localparam int          XY_WORDS      = 256;
  localparam int          STOP_LONG_CYC = 65535;
  localparam int          STOP_SHORT_CYC = 8;
  localparam logic [2:0]  MODE_NORMAL   = 3'b000;
  localparam logic [2:0]  MODE_EMI      = 3'b001;
  localparam logic [2:0]  MODE_PROM     = 3'b010;
  localparam logic [2:0]  MODE_SPI      = 3'b101;
  localparam logic [2:0]  MODE_I2C      = 3'b111;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_CLEAR = 3'b001,
    ST_LOAD  = 3'b011,
    ST_DONE  = 3'b010,
    ST_STOP  = 3'b110,
    ST_WAKE  = 3'b111
  } boot_state_t;
endpackage

// ---- testbench/load_source.sv ----
`timescale 1ns/1ps
`default_nettype none
module load_source (
  input  wire logic        clk,
  input  wire logic        load_active,
  input  wire logic [3:0]  gap,
  output logic             load_word_valid,
  output logic [23:0]      load_word
);
  logic [3:0] cnt;
  initial begin
    cnt = 4'h0;
    load_word_valid = 1'b0;
    load_word = 24'h00_0000;
  end
  // words only while loading
  // gap sets a prompt or a slow host; idle data toggles so nothing stale passes
  always @(posedge clk) begin
    load_word_valid <= 1'b0;
    load_word <= ~load_word;
    cnt <= cnt + 4'h1;
    if (load_active && cnt >= gap) begin
      cnt <= 4'h0;
      load_word_valid <= 1'b1;
      load_word <= 24'($urandom);
    end
  end
endmodule
`default_nettype wire

// ---- testbench/boot_mode_memory_decode_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module boot_mode_memory_decode_test;
  import boot_mode_pkg::*;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [2:0]  pins = 3'b001;
  logic [2:0]  cm = 3'b001;
  logic [3:0]  gap = 4'h2;
  logic        stop_request = 1'b0;
  logic        mem_req = 1'b0;
  logic        mem_write = 1'b0;
  logic        mem_fetch = 1'b0;
  logic [15:0] mem_addr = 16'h0000;
  logic [31:0] avs_readdata;
  logic [23:0] load_word, reserved_data;
  logic [15:0] jump_addr;
  logic [8:0]  clear_addr, load_addr;
  logic        avs_waitrequest, load_word_valid, boot_rom_enable, program_rom_sel;
  logic        program_ram_enable, periph_sel, mem_write_allow, reserved_hit;
  logic        debug_port_enable, clear_xy_active, load_active, boot_chip_select_n;
  logic        serial_spi_slave, serial_i2c_slave, jump_valid, core_run;
  logic        saw_clr, ld_seen;
  logic [31:0] rq[$];
  logic [31:0] jq[$];
  int          n_fail = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          d0, d1;
  // straps use only the defined mode codes
  logic [2:0]  modes[5] = '{3'b001, 3'b101, 3'b111, 3'b000, 3'b010};
  logic [15:0] addrs[8] = '{16'h2000, 16'h47FF, 16'h4800, 16'hFFDF, 16'hFFE0, 16'hFFFF,
                            16'h0010, 16'h9000};

  boot_mode_memory_decode #(.STOP_LONG(20), .LOAD_MAX(4), .CLEAR_WORDS(4)) i_dut (
    .clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .mode_pin_high(pins[2]), .mode_pin_middle(pins[1]),
    .mode_pin_low(pins[0]), .stop_request, .load_word_valid, .load_word, .mem_req,
    .mem_write, .mem_fetch, .mem_addr, .boot_rom_enable, .program_rom_sel,
    .program_ram_enable, .periph_sel, .mem_write_allow, .reserved_hit, .reserved_data,
    .debug_port_enable, .clear_xy_active, .clear_addr, .load_active, .load_addr,
    .boot_chip_select_n, .serial_spi_slave, .serial_i2c_slave, .jump_valid, .jump_addr,
    .core_run);
  load_source i_src (.clk, .load_active, .gap, .load_word_valid, .load_word);

  always #2 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    if (n_fail == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] omr_of(input logic [2:0] m);
    return {27'h000_0000, m[2], 2'b00, m[1:0]};
  endfunction
  // a read notes its expected word; the monitor below compares it
  task automatic acc(input bit w, input logic [3:0] a, input logic [31:0] d);
    if (!w) rq.push_back(d);
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic do_reset(input logic [2:0] m);
    @(posedge clk);
    rstn <= 1'b0;
    pins <= m;
    cm <= (m == MODE_NORMAL) ? MODE_EMI : m;
    gap <= 4'($urandom_range(2, 9));
    jq.push_back(m == MODE_PROM ? ROM_CONT_ADDR : RESET_VECTOR);
    tick(20);
    chk(debug_port_enable, 1);
    @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  // k selects data read, fetch or write; results show one cycle after the probe
  task automatic probe(input int k, input logic [15:0] a);
    logic res;
    res = (a >= 16'h4800 && a <= 16'hFFDF);
    @(posedge clk);
    mem_req <= 1'b1;
    mem_fetch <= (k == 1);
    mem_write <= (k == 2);
    mem_addr <= a;
    @(posedge clk);
    mem_req <= 1'b0;
    #1;
    chk(reserved_hit, res);
    if (res && k != 2) chk(reserved_data, RESERVED_WORD);
    if (k == 2) chk(mem_write_allow, !res && !(a >= PROM_LO && a <= PROM_HI));
    if (k == 1) chk(program_rom_sel, a >= PROM_LO && a <= PROM_HI);
    if (k == 0 && a >= PERIPH_ASSIGNED_LO) chk(periph_sel, 1);
  endtask
  task automatic wake(output int n);
    @(posedge clk);
    stop_request <= 1'b1;
    repeat (5) @(posedge clk);
    stop_request <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (core_run !== 1'b1 && n < 500);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      test_done();
    end
  end
  always @(posedge clk) begin
    if (!rstn) begin
      saw_clr <= 1'b0;
      ld_seen <= 1'b0;
    end else if (clear_xy_active === 1'b1) begin
      saw_clr <= 1'b1;
    end
    if (avs_read && avs_waitrequest === 1'b0) chk(avs_readdata, rq.pop_front());
    if (jump_valid === 1'b1) begin
      chk(jq.size(), 1);
      chk(jump_addr, jq.pop_front());
    end
    if (load_active === 1'b1 && !ld_seen) begin
      ld_seen <= 1'b1;
      chk(saw_clr, 1);
      chk(debug_port_enable, 1);
      chk({boot_chip_select_n, serial_spi_slave, serial_i2c_slave},
          {cm != MODE_EMI, cm == MODE_SPI, cm == MODE_I2C});
    end
  end
  initial begin
    void'($urandom(82519));
    foreach (modes[i]) begin
      do_reset(modes[i]);
      if (modes[i] != MODE_PROM) acc(0, REG_MODE_CTRL, omr_of(cm));
      for (int k = 0; k < 2000 && jq.size() != 0; k++) @(posedge clk);
      tick(2);
      chk(ld_seen, modes[i] != MODE_PROM);
      if (modes[i] != MODE_PROM) acc(0, REG_MODE_CTRL, 32'h0000_0000);
    end
    acc(1, REG_MODE_CTRL, 32'hFF00_004C);
    acc(0, REG_MODE_CTRL, 32'h0000_004C);
    tick(2);
    chk({boot_rom_enable, program_ram_enable}, 2'b01);
    acc(1, 4'h2, 32'h0000_0013);
    acc(0, 4'h2, 32'h0000_0000);
    acc(0, REG_MODE_CTRL, 32'h0000_004C);
    acc(1, REG_MODE_CTRL, 32'h0000_0053);
    tick(2);
    chk(boot_rom_enable, 1);
    wake(d1);
    acc(1, REG_MODE_CTRL, 32'h0000_0013);
    wake(d0);
    chk(d0 - d1, 20 - STOP_SHORT_CYC);
    chk(d1 >= STOP_SHORT_CYC, 1);
    addrs[7] = 16'($urandom_range(32'h4800, 32'hFFDF));
    foreach (addrs[i]) for (int k = 0; k < 3; k++) probe(k, addrs[i]);
    tick(2);
    chk(rq.size() + jq.size(), 0);
    test_done();
  end
endmodule
`default_nettype wire
